/* File: hw/acd_pkg.sv */
// package of the command class decoder: register map, field positions, classes and reset values
// assumes an 8-bit register port with byte-wide data and a 4-bit address
`default_nettype none
package acd_pkg;
  // register offsets
  localparam logic [3:0] ACD_REG_DATA = 4'h0;
  localparam logic [3:0] ACD_REG_ERR_FEAT = 4'h1;
  localparam logic [3:0] ACD_REG_SECCNT = 4'h2;
  localparam logic [3:0] ACD_REG_LBA_LO = 4'h3;
  localparam logic [3:0] ACD_REG_LBA_MID = 4'h4;
  localparam logic [3:0] ACD_REG_LBA_HI = 4'h5;
  localparam logic [3:0] ACD_REG_DEVICE = 4'h6;
  localparam logic [3:0] ACD_REG_STAT_CMD = 4'h7;
  localparam logic [3:0] ACD_REG_INT_STAT = 4'h8;
  localparam logic [3:0] ACD_REG_INT_MASK = 4'h9;
  localparam logic [3:0] ACD_REG_CTRL = 4'hA;
  // status byte fields
  localparam int ACD_ST_ERR = 0;
  localparam int ACD_ST_DRQ = 3;
  localparam int ACD_ST_RDY = 6;
  localparam int ACD_ST_BSY = 7;
  // error byte field and device register fields
  localparam int ACD_ER_ABT = 2;
  localparam int ACD_DEV_LBA = 6;
  localparam logic [7:0] ACD_ERR_ABORT = 8'h04;
  localparam logic [7:0] ACD_DEV_RST = 8'h00;
  // control register field
  localparam int ACD_CTRL_LONG = 0;
  // interrupt status / mask fields
  localparam int ACD_INT_DONE = 0;
  localparam int ACD_INT_ERR = 1;
  localparam int ACD_INT_DRQ = 2;
  localparam int ACD_INT_W = 3;
  localparam logic [2:0] ACD_INT_MASK_RST = 3'h7;
  // protocol classes
  localparam logic [2:0] ACD_CLS_NONE = 3'h0;
  localparam logic [2:0] ACD_CLS_DIN = 3'h1;
  localparam logic [2:0] ACD_CLS_DOUT = 3'h2;
  localparam logic [2:0] ACD_CLS_ND = 3'h3;
  localparam logic [2:0] ACD_CLS_DMA = 3'h4;
  localparam logic [2:0] ACD_CLS_FPDMA = 3'h5;
  // sector sizing; a sector count of zero means the largest count
  localparam int ACD_SECTOR_BYTES = 512;
  localparam int ACD_LONG_EXTRA = 4;
  localparam logic [8:0] ACD_SECT_MAX = 9'h100;
  typedef enum logic [1:0] {ACD_S_IDLE, ACD_S_DIN, ACD_S_DOUT, ACD_S_WAIT} acd_state_t;
endpackage
`default_nettype wire

/* File: hw/acd_dec_if.sv */
// interface between the command front end and the opcode class decoder
// assumes the decoder is purely combinational
`default_nettype none
interface acd_dec_if;
  logic [7:0] opcode;
  logic [7:0] feature;
  logic [2:0] cls;
  logic vendor;
  modport dec (input opcode, input feature, output cls, output vendor);
  modport user (output opcode, output feature, input cls, input vendor);
endinterface
`default_nettype wire

/* File: hw/acd_class_decoder.sv */
// opcode to protocol class decoder
// assumes opcode and subcommand feature are stable while the class is used
`default_nettype none
module acd_class_decoder
  import acd_pkg::*;
(
  acd_dec_if.dec dif
);
  always_comb begin
    dif.vendor = 1'b0;
    case (dif.opcode)
      8'hE5, 8'h98, 8'h90, 8'h91, 8'hE7, 8'hEA, 8'hEF: dif.cls = ACD_CLS_ND;
      8'hE3, 8'hE1, 8'h97, 8'h95: dif.cls = ACD_CLS_ND;
      8'hF8, 8'h27: dif.cls = ACD_CLS_ND;
      8'h40, 8'h41, 8'h42: dif.cls = ACD_CLS_ND;
      8'hF3, 8'hF5: dif.cls = ACD_CLS_ND;
      8'hF1, 8'hF2, 8'hF4, 8'hF6: dif.cls = ACD_CLS_DOUT;
      8'h92, 8'h50: dif.cls = ACD_CLS_DOUT;
      8'hEC, 8'hE4, 8'h2F, 8'hC4, 8'h29, 8'h20, 8'h21, 8'h24: dif.cls = ACD_CLS_DIN;
      8'hC8, 8'hC9, 8'h25: dif.cls = ACD_CLS_DMA;
      8'h60: dif.cls = ACD_CLS_FPDMA;
      8'hF7, 8'hF0: begin
        // vendor specific non-data commands
        dif.cls = ACD_CLS_ND;
        dif.vendor = 1'b1;
      end
      8'hB1: begin
        case (dif.feature)
          8'hC0, 8'hC1: dif.cls = ACD_CLS_ND;
          8'hC2: dif.cls = ACD_CLS_DIN;
          8'hC3: dif.cls = ACD_CLS_DOUT;
          default: dif.cls = ACD_CLS_NONE;
        endcase
      end
      default: dif.cls = ACD_CLS_NONE;
    endcase
  end
endmodule
`default_nettype wire

/* File: hw/ata_command_class_decoder.sv */
// command protocol front end: task file registers, class sorting, status/error handshake
// assumes a one-cycle register port and a drive back end that answers with one-cycle pulses
`default_nettype none
module ata_command_class_decoder
  import acd_pkg::*;
#(
  parameter int SECTOR_BYTES = ACD_SECTOR_BYTES,
  parameter int LONG_EXTRA = ACD_LONG_EXTRA
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic intrq,
  output logic be_cmd_start,
  output logic [7:0] be_opcode,
  output logic [2:0] be_class,
  output logic be_lba_mode,
  input wire logic be_sect_ok,
  input wire logic be_done,
  input wire logic be_param_bad,
  input wire logic be_err,
  input wire logic [7:0] be_err_code,
  input wire logic [27:0] be_fail_lba,
  input wire logic [15:0] be_fail_cyl,
  input wire logic [3:0] be_fail_head,
  input wire logic [7:0] be_fail_sect,
  input wire logic [7:0] be_rd_data,
  output logic be_rd_ready,
  output logic [7:0] be_wr_data,
  output logic be_wr_valid
);
  typedef struct packed {
    acd_state_t state;
    logic bsy;
    logic drq;
    logic err;
    logic [7:0] error;
    logic [7:0] feature;
    logic [7:0] seccnt;
    logic [7:0] lba_lo;
    logic [7:0] lba_mid;
    logic [7:0] lba_hi;
    logic [7:0] device;
    logic [7:0] opcode;
    logic [2:0] cls;
    logic lba_mode;
    logic [8:0] sect_left;
    logic [9:0] byte_cnt;
    logic [7:0] rdata;
    logic [ACD_INT_W-1:0] ist;
    logic [ACD_INT_W-1:0] imask;
    logic ctrl_long;
    logic start;
    logic [7:0] wr_data;
    logic wr_valid;
  } acd_regs_t;

  acd_regs_t r;
  acd_regs_t next_r;
  acd_dec_if dif ();
  logic cmd_acc;
  logic din_rd;
  logic dout_wr;
  logic [9:0] sec_last;
  logic active;
  logic [7:0] status;

  acd_class_decoder u_dec (
    .dif(dif.dec)
  );

  assign dif.opcode = reg_wdata;
  assign dif.feature = r.feature;
  // a command is taken only when idle, or when a failed data-in still shows its request
  assign cmd_acc = reg_wr && reg_addr == ACD_REG_STAT_CMD && !r.bsy && (!r.drq || r.err);
  assign din_rd = reg_rd && reg_addr == ACD_REG_DATA && r.state == ACD_S_DIN && r.drq;
  assign dout_wr = reg_wr && reg_addr == ACD_REG_DATA && r.state == ACD_S_DOUT && r.drq;
  assign sec_last = r.ctrl_long ? 10'(SECTOR_BYTES + LONG_EXTRA - 1) : 10'(SECTOR_BYTES - 1);
  assign active = r.state != ACD_S_IDLE;

  always_comb begin
    status = 8'h00;
    status[ACD_ST_BSY] = r.bsy;
    status[ACD_ST_RDY] = 1'b1;
    status[ACD_ST_DRQ] = r.drq;
    status[ACD_ST_ERR] = r.err;
  end

  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.wr_valid = 1'b0;
    next_r.rdata = 8'h00;
    // register reads
    if (reg_rd) begin
      if (reg_addr == ACD_REG_DATA) begin
        next_r.rdata = din_rd ? be_rd_data : 8'h00;
      end else if (reg_addr == ACD_REG_ERR_FEAT) begin
        next_r.rdata = r.error;
      end else if (reg_addr == ACD_REG_SECCNT) begin
        next_r.rdata = r.seccnt;
      end else if (reg_addr == ACD_REG_LBA_LO) begin
        next_r.rdata = r.lba_lo;
      end else if (reg_addr == ACD_REG_LBA_MID) begin
        next_r.rdata = r.lba_mid;
      end else if (reg_addr == ACD_REG_LBA_HI) begin
        next_r.rdata = r.lba_hi;
      end else if (reg_addr == ACD_REG_DEVICE) begin
        next_r.rdata = r.device;
      end else if (reg_addr == ACD_REG_STAT_CMD) begin
        next_r.rdata = status;
      end else if (reg_addr == ACD_REG_INT_STAT) begin
        next_r.rdata = {5'h00, r.ist};
        next_r.ist = '0;
      end else if (reg_addr == ACD_REG_INT_MASK) begin
        next_r.rdata = {5'h00, r.imask};
      end else if (reg_addr == ACD_REG_CTRL) begin
        next_r.rdata = {7'h00, r.ctrl_long};
      end
    end
    // register writes; the task file is frozen while busy
    if (reg_wr) begin
      if (reg_addr == ACD_REG_INT_MASK) begin
        next_r.imask = reg_wdata[ACD_INT_W-1:0];
      end else if (reg_addr == ACD_REG_CTRL) begin
        next_r.ctrl_long = reg_wdata[ACD_CTRL_LONG];
      end else if (!r.bsy) begin
        if (reg_addr == ACD_REG_ERR_FEAT) begin
          next_r.feature = reg_wdata;
        end else if (reg_addr == ACD_REG_SECCNT) begin
          next_r.seccnt = reg_wdata;
        end else if (reg_addr == ACD_REG_LBA_LO) begin
          next_r.lba_lo = reg_wdata;
        end else if (reg_addr == ACD_REG_LBA_MID) begin
          next_r.lba_mid = reg_wdata;
        end else if (reg_addr == ACD_REG_LBA_HI) begin
          next_r.lba_hi = reg_wdata;
        end else if (reg_addr == ACD_REG_DEVICE) begin
          next_r.device = reg_wdata;
        end
      end
    end
    // command issue
    if (cmd_acc) begin
      next_r.opcode = reg_wdata;
      next_r.lba_mode = r.device[ACD_DEV_LBA];
      next_r.cls = dif.cls;
      next_r.err = 1'b0;
      next_r.error = 8'h00;
      next_r.drq = 1'b0;
      next_r.byte_cnt = '0;
      next_r.sect_left = (r.seccnt == 8'h00) ? ACD_SECT_MAX : {1'b0, r.seccnt};
      if (dif.cls == ACD_CLS_NONE) begin
        next_r.state = ACD_S_IDLE;
        next_r.bsy = 1'b0;
        next_r.err = 1'b1;
        next_r.error = ACD_ERR_ABORT;
        next_r.ist[ACD_INT_ERR] = 1'b1;
      end else begin
        next_r.start = 1'b1;
        case (dif.cls)
          ACD_CLS_DIN: begin
            next_r.state = ACD_S_DIN;
            next_r.bsy = 1'b1;
          end
          ACD_CLS_DOUT: begin
            // first sector is requested at once
            next_r.state = ACD_S_DOUT;
            next_r.drq = 1'b1;
            next_r.bsy = 1'b0;
            next_r.ist[ACD_INT_DRQ] = 1'b1;
          end
          default: begin
            // non-data, DMA and queued DMA wait for the back end
            next_r.state = ACD_S_WAIT;
            next_r.bsy = 1'b1;
          end
        endcase
      end
    end else if (active && be_param_bad && r.state != ACD_S_WAIT) begin
      next_r.state = ACD_S_IDLE;
      next_r.bsy = 1'b0;
      next_r.drq = 1'b0;
      next_r.err = 1'b1;
      next_r.error = ACD_ERR_ABORT;
      next_r.ist[ACD_INT_ERR] = 1'b1;
    end else if (active && be_err) begin
      next_r.state = ACD_S_IDLE;
      next_r.bsy = 1'b0;
      next_r.err = 1'b1;
      next_r.error = be_err_code;
      next_r.drq = r.state == ACD_S_DIN;
      next_r.ist[ACD_INT_ERR] = 1'b1;
      if (r.lba_mode) begin
        next_r.lba_lo = be_fail_lba[7:0];
        next_r.lba_mid = be_fail_lba[15:8];
        next_r.lba_hi = be_fail_lba[23:16];
        next_r.device[3:0] = be_fail_lba[27:24];
      end else begin
        next_r.lba_lo = be_fail_sect;
        next_r.lba_mid = be_fail_cyl[7:0];
        next_r.lba_hi = be_fail_cyl[15:8];
        next_r.device[3:0] = be_fail_head;
      end
    end else begin
      case (r.state)
        ACD_S_DIN: begin
          if (r.bsy && be_sect_ok) begin
            // status goes up together with the data request
            next_r.bsy = 1'b0;
            next_r.drq = 1'b1;
            next_r.ist[ACD_INT_DRQ] = 1'b1;
          end else if (din_rd) begin
            next_r.byte_cnt = r.byte_cnt + 10'h001;
            if (r.byte_cnt == sec_last) begin
              next_r.byte_cnt = '0;
              next_r.drq = 1'b0;
              next_r.sect_left = r.sect_left - 9'h001;
              if (r.sect_left == 9'h001) begin
                next_r.state = ACD_S_IDLE;
                next_r.ist[ACD_INT_DONE] = 1'b1;
              end else begin
                next_r.bsy = 1'b1;
              end
            end
          end
        end
        ACD_S_DOUT: begin
          if (dout_wr) begin
            next_r.wr_data = reg_wdata;
            next_r.wr_valid = 1'b1;
            next_r.byte_cnt = r.byte_cnt + 10'h001;
            if (r.byte_cnt == sec_last) begin
              next_r.byte_cnt = '0;
              next_r.drq = 1'b0;
              next_r.bsy = 1'b1;
            end
          end else if (r.bsy && be_sect_ok) begin
            next_r.bsy = 1'b0;
            next_r.sect_left = r.sect_left - 9'h001;
            if (r.sect_left == 9'h001) begin
              next_r.state = ACD_S_IDLE;
              next_r.ist[ACD_INT_DONE] = 1'b1;
            end else begin
              next_r.drq = 1'b1;
              next_r.ist[ACD_INT_DRQ] = 1'b1;
            end
          end
        end
        ACD_S_WAIT: begin
          if (be_done) begin
            next_r.state = ACD_S_IDLE;
            next_r.bsy = 1'b0;
            next_r.ist[ACD_INT_DONE] = 1'b1;
          end
        end
        default: begin
          next_r.state = ACD_S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= ACD_S_IDLE;
      r.device <= ACD_DEV_RST;
      r.imask <= ACD_INT_MASK_RST;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign intrq = |(r.ist & r.imask);
  assign be_cmd_start = r.start;
  assign be_opcode = r.opcode;
  assign be_class = r.cls;
  assign be_lba_mode = r.lba_mode;
  assign be_rd_ready = din_rd;
  assign be_wr_data = r.wr_data;
  assign be_wr_valid = r.wr_valid;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  abort_unknown_a: assert property (cmd_acc && dif.cls == ACD_CLS_NONE |=>
    !r.bsy && r.err && r.error[ACD_ER_ABT] && !r.drq && !be_cmd_start) else $error("unknown opcode not aborted");
  param_abort_a: assert property (active && !cmd_acc && be_param_bad && r.state != ACD_S_WAIT |=>
    !r.bsy && r.err && r.error[ACD_ER_ABT] && r.state == ACD_S_IDLE) else $error("bad parameter not aborted");
  din_error_a: assert property (r.state == ACD_S_DIN && be_err && !be_param_bad && !cmd_acc |=>
    !r.bsy && r.err && r.drq && r.error == $past(be_err_code)) else $error("data-in error status wrong");
  dout_error_a: assert property (r.state == ACD_S_DOUT && be_err && !be_param_bad && !cmd_acc |=>
    !r.bsy && r.err && !r.drq && (intrq || !r.imask[ACD_INT_ERR])) else $error("data-out error status wrong");
  lba_report_a: assert property (active && be_err && !be_param_bad && !cmd_acc && r.lba_mode |=>
    {r.device[3:0], r.lba_hi, r.lba_mid, r.lba_lo} == $past(be_fail_lba)) else $error("lba location wrong");
  chs_report_a: assert property (active && be_err && !be_param_bad && !cmd_acc && !r.lba_mode |=>
    r.lba_lo == $past(be_fail_sect) && {r.lba_hi, r.lba_mid} == $past(be_fail_cyl)) else $error("chs location wrong");
  status_first_a: assert property (r.state == ACD_S_DIN && r.bsy && be_sect_ok && !be_err && !be_param_bad |=>
    r.drq && !r.bsy ##0 !be_rd_ready[*1]) else $error("data moved before status posted");
  din_sector_a: assert property (din_rd && r.byte_cnt == sec_last && r.sect_left > 9'h001 |=>
    r.bsy && !r.drq && r.byte_cnt == 10'h000 ##1 !be_rd_ready) else $error("data-in sector boundary wrong");
  dout_sector_a: assert property (dout_wr && r.byte_cnt == sec_last |=>
    be_wr_valid && r.bsy && !r.drq && be_wr_data == $past(reg_wdata)) else $error("data-out sector boundary wrong");
  no_data_a: assert property (r.state == ACD_S_WAIT |-> !r.drq && !be_rd_ready && !be_wr_valid)
    else $error("data phase in non-data command");
  queued_class_a: assert property (cmd_acc && reg_wdata == 8'h60 |=> be_class == ACD_CLS_FPDMA && be_cmd_start)
    else $error("queued opcode misclassified");
  verify_class_a: assert property (cmd_acc && (reg_wdata == 8'h40 || reg_wdata == 8'h42 || reg_wdata == 8'hF8) |=>
    be_class == ACD_CLS_ND && r.state == ACD_S_WAIT) else $error("verify opcode misclassified");
  vendor_class_a: assert property (cmd_acc && dif.vendor |=> be_class == ACD_CLS_ND && r.state == ACD_S_WAIT)
    else $error("vendor opcode misclassified");

  din_done_c: cover property (r.state == ACD_S_DIN ##1 r.state == ACD_S_IDLE && !r.err);
  dout_done_c: cover property (r.state == ACD_S_DOUT ##1 r.state == ACD_S_IDLE && !r.err);
  abort_c: cover property (cmd_acc && dif.cls == ACD_CLS_NONE);
  din_err_c: cover property (r.state == ACD_S_DIN && be_err);
endmodule
`default_nettype wire

/* File: testbench/acd_be_model.sv */
// back end model: answers the front end with sector, done and error pulses
// assumes the bench sets sector count, long mode and error injection
`default_nettype none
module acd_be_model
  import acd_pkg::*;
#(
  parameter int BPS = 16,
  parameter int EXT = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic be_cmd_start,
  input wire logic [2:0] be_class,
  input wire logic be_rd_ready,
  input wire logic be_wr_valid,
  input wire logic [8:0] n_sect,
  input wire logic long_mode,
  input wire logic [1:0] err_mode,
  output logic be_sect_ok,
  output logic be_done,
  output logic be_param_bad,
  output logic be_err,
  output logic [7:0] be_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_c, bytes, idx, left, cls_q;
  bit pend;
  // data-in pattern follows the byte index of the command
  assign be_rd_data = 8'(idx) ^ 8'hA5;
  always @(posedge core_clk) begin
    be_sect_ok <= 1'b0;
    be_done <= 1'b0;
    be_param_bad <= 1'b0;
    be_err <= 1'b0;
    if (!rst_n) begin
      pend <= 1'b0;
      idx <= 0;
    end else if (be_cmd_start) begin
      cls_q <= int'(be_class);
      left <= (n_sect == 9'h000) ? 256 : int'(n_sect);
      bytes <= 0;
      idx <= 0;
      // data-out starts with the host, so nothing to answer unless an error is due
      pend <= (be_class != ACD_CLS_DOUT) || (err_mode != 2'h0);
      wait_c <= $urandom_range(8, 1);
    end else if (pend) begin
      if (wait_c > 0) wait_c <= wait_c - 1;
      else begin
        pend <= 1'b0;
        if (err_mode == 2'h1) be_param_bad <= 1'b1;
        else if (err_mode == 2'h2) be_err <= 1'b1;
        else if (cls_q == 1 || cls_q == 2) be_sect_ok <= 1'b1;
        else be_done <= 1'b1;
      end
    end else if (be_rd_ready || be_wr_valid) begin
      idx <= idx + 1;
      if (bytes + 1 < BPS + (long_mode ? EXT : 0)) bytes <= bytes + 1;
      else begin
        bytes <= 0;
        left <= left - 1;
        pend <= (cls_q == 2) || (left > 1);
        wait_c <= $urandom_range(8, 1);
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench of the command class decoder
// assumes the design package, design and back end model are compiled first
`default_nettype none
module tb_top
  import acd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BPS = 16;
  localparam int EXT = 4;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, long_mode = 1'b0;
  logic [3:0] reg_addr = 4'h0, be_fail_head = 4'h0;
  logic [7:0] reg_wdata = 8'h00, be_err_code = 8'h00, be_fail_sect = 8'h00, rv, d;
  logic [27:0] be_fail_lba = 28'h0;
  logic [15:0] be_fail_cyl = 16'h0;
  logic [8:0] n_sect = 9'h001;
  logic [1:0] err_mode = 2'h0;
  logic [7:0] reg_rdata, be_opcode, be_rd_data, be_wr_data;
  logic [2:0] be_class;
  logic [19:0] t;
  logic [7:0] wr_q[$];
  logic intrq, be_cmd_start, be_lba_mode, be_sect_ok, be_done, be_param_bad, be_err, be_rd_ready, be_wr_valid;
  int mismatches = 0, checked = 0, starts = 0, i, k, ns, bps;
  // opcode, feature, expected class
  logic [19:0] tbl [35] = '{
    20'hEC001, 20'hE4001, 20'h20001, 20'h2F001, 20'hB1C21, 20'hB1C32, 20'h92002, 20'hF1002,
    20'hF2002, 20'hF4002, 20'hF6002, 20'h50002, 20'hB1C03, 20'hB1C13, 20'h90003, 20'h91003,
    20'h40003, 20'h41003, 20'h42003, 20'hF8003, 20'h27003, 20'hE3003, 20'hE1003, 20'h97003,
    20'h95003, 20'hF3003, 20'hF5003, 20'hE5003, 20'hC8004, 20'h25004, 20'h60005, 20'h13000,
    20'h70000, 20'hB1000, 20'hF7003};

  always #5 core_clk = ~core_clk;

  ata_command_class_decoder #(.SECTOR_BYTES(BPS), .LONG_EXTRA(EXT)) i_ata_command_class_decoder (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .intrq,
    .be_cmd_start, .be_opcode, .be_class, .be_lba_mode, .be_sect_ok, .be_done,
    .be_param_bad, .be_err, .be_err_code, .be_fail_lba, .be_fail_cyl, .be_fail_head,
    .be_fail_sect, .be_rd_data, .be_rd_ready, .be_wr_data, .be_wr_valid);

  acd_be_model #(.BPS(BPS), .EXT(EXT)) i_acd_be_model (
    .core_clk, .rst_n, .be_cmd_start, .be_class, .be_rd_ready, .be_wr_valid,
    .n_sect, .long_mode, .err_mode, .be_sect_ok, .be_done, .be_param_bad, .be_err, .be_rd_data);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // polls status until busy is clear, bounded
  task automatic wait_nb(output logic [7:0] s);
    int n;
    n = 0;
    s = 8'h80;
    while (s[ACD_ST_BSY] !== 1'b0 && n < 300) begin
      rd(ACD_REG_STAT_CMD, s);
      n++;
    end
    if (n >= 300) chk(s, 8'h00);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] ft);
    logic [7:0] s;
    wait_nb(s);
    wr(ACD_REG_ERR_FEAT, ft);
    wr(ACD_REG_STAT_CMD, op);
  endtask

  always @(posedge core_clk) begin
    if (be_cmd_start === 1'b1) starts++;
    if (be_wr_valid === 1'b1) chk(be_wr_data, wr_q.pop_front());
  end

  initial begin
    #500000;
    mismatches++;
    stop_test();
  end

  initial begin
    void'($urandom(32'hB340C905));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    chk(intrq, 1'b0);
    rdc(ACD_REG_STAT_CMD, 8'h40);
    rdc(ACD_REG_INT_MASK, {5'h00, ACD_INT_MASK_RST});
    rdc(ACD_REG_DEVICE, ACD_DEV_RST);
    rdc(4'hB, 8'h00);
    // every listed opcode; data-in and data-out classes are aborted by a bad parameter
    foreach (tbl[j]) begin
      t = tbl[j];
      err_mode <= (t[2:0] == ACD_CLS_DIN || t[2:0] == ACD_CLS_DOUT) ? 2'h1 : 2'h0;
      k = starts;
      cmd(t[19:12], t[11:4]);
      // data-out is never busy at first, so give the back end time to answer
      repeat (16) @(posedge core_clk);
      wait_nb(rv);
      if (t[2:0] inside {ACD_CLS_NONE, ACD_CLS_DIN, ACD_CLS_DOUT}) begin
        chk(rv, 8'h41);
        rdc(ACD_REG_ERR_FEAT, ACD_ERR_ABORT);
      end else chk(rv, 8'h40);
      chk(starts - k, (t[2:0] == ACD_CLS_NONE) ? 0 : 1);
      if (t[2:0] != ACD_CLS_NONE) chk({be_opcode, be_class}, {t[19:12], t[2:0]});
    end
    err_mode <= 2'h0;
    // two plain sectors, then one long sector
    for (i = 0; i < 2; i++) begin
      ns = 2 - i;
      bps = BPS + i * EXT;
      long_mode <= i[0];
      n_sect <= 9'(ns);
      wr(ACD_REG_CTRL, 8'(i));
      wr(ACD_REG_SECCNT, 8'(ns));
      cmd(8'h20, 8'h00);
      for (k = 0; k < ns * bps; k++) begin
        if (k % bps == 0) begin
          wait_nb(rv);
          chk(rv, 8'h48);
        end
        rdc(ACD_REG_DATA, 8'(k) ^ 8'hA5);
      end
      wait_nb(rv);
      chk(rv, 8'h40);
    end
    long_mode <= 1'b0;
    n_sect <= 9'h001;
    wr(ACD_REG_CTRL, 8'h00);
    wr(ACD_REG_SECCNT, 8'h01);
    cmd(8'h92, 8'h00);
    wait_nb(rv);
    chk(rv, 8'h48);
    for (k = 0; k < BPS; k++) begin
      d = 8'($urandom);
      wr_q.push_back(d);
      wr(ACD_REG_DATA, d);
    end
    wait_nb(rv);
    chk(rv, 8'h40);
    chk(wr_q.size(), 0);
    // media error: data-in in address mode, data-out in geometry mode
    for (i = 0; i < 2; i++) begin
      be_err_code <= 8'($urandom_range(255, 1));
      be_fail_lba <= 28'($urandom);
      be_fail_cyl <= 16'($urandom);
      be_fail_head <= 4'($urandom);
      be_fail_sect <= 8'($urandom);
      err_mode <= 2'h2;
      wr(ACD_REG_DEVICE, (i == 0) ? 8'h40 : 8'h00);
      cmd((i == 0) ? 8'h24 : 8'hF2, 8'h00);
      repeat (16) @(posedge core_clk);
      wait_nb(rv);
      chk(rv, (i == 0) ? 8'h49 : 8'h41);
      rdc(ACD_REG_ERR_FEAT, be_err_code);
      chk(be_lba_mode, (i == 0) ? 1'b1 : 1'b0);
      rdc(ACD_REG_LBA_LO, (i == 0) ? be_fail_lba[7:0] : be_fail_sect);
      rdc(ACD_REG_LBA_MID, (i == 0) ? be_fail_lba[15:8] : be_fail_cyl[7:0]);
      rdc(ACD_REG_LBA_HI, (i == 0) ? be_fail_lba[23:16] : be_fail_cyl[15:8]);
      rd(ACD_REG_DEVICE, rv);
      chk(rv[3:0], (i == 0) ? be_fail_lba[27:24] : be_fail_head);
    end
    err_mode <= 2'h0;
    // interrupt masked, unmasked, then cleared by reading
    rd(ACD_REG_INT_STAT, rv);
    wr(ACD_REG_INT_MASK, 8'h00);
    cmd(8'hE7, 8'h00);
    wait_nb(rv);
    chk(intrq, 1'b0);
    wr(ACD_REG_INT_MASK, 8'h01);
    @(posedge core_clk);
    #1 chk(intrq, 1'b1);
    rdc(ACD_REG_INT_STAT, 8'h01);
    @(posedge core_clk);
    #1 chk(intrq, 1'b0);
    rdc(ACD_REG_INT_STAT, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
